// file: core/ictb_fifo.v
`include "ictb_map.vh"
// Capture FIFO with an array of entries; a push while full is dropped unless a pop frees a slot in the same cycle
module ictb_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH_LOG2 = 2
) (
	input  wire             ref_clk_in,   // System clock
	input  wire             rst_b_in,     // Sync reset, active low
	input  wire             clr_in,       // Flush all entries
	input  wire             push_in,      // Write one entry
	input  wire [WIDTH-1:0] push_data_in, // Entry value
	input  wire             pop_in,       // Remove head entry
	output reg  [WIDTH-1:0] head_out,     // Head entry value
	output wire             empty_out,    // No entries
	output wire             full_out,     // No free entry
	output wire [DEPTH_LOG2:0] count_out  // Entries held
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [WIDTH-1:0]      mem_r [0:DEPTH-1];
	reg [DEPTH_LOG2-1:0] wp_r;
	reg [DEPTH_LOG2-1:0] rp_r;
	reg [DEPTH_LOG2:0]   cnt_r;
	wire do_push;
	wire do_pop;

	assign empty_out = (cnt_r == {(DEPTH_LOG2+1){1'b0}});
	assign full_out  = cnt_r[DEPTH_LOG2];
	assign count_out = cnt_r;
	assign do_pop  = pop_in & ~empty_out;
	// Pop frees a slot in the same cycle, so push while full+pop is kept
	assign do_push = push_in & (~full_out | do_pop);

	// Pointer and count update
	always @(posedge ref_clk_in) begin
		if (!rst_b_in || clr_in) begin
			wp_r  <= {DEPTH_LOG2{1'b0}};
			rp_r  <= {DEPTH_LOG2{1'b0}};
			cnt_r <= {(DEPTH_LOG2+1){1'b0}};
		end else begin
			if (do_push)
				wp_r <= wp_r + 1'b1;
			if (do_pop)
				rp_r <= rp_r + 1'b1;
			if (do_push && !do_pop)
				cnt_r <= cnt_r + 1'b1;
			else if (do_pop && !do_push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	// Storage has no reset; only written slots are ever read
	always @(posedge ref_clk_in) begin
		if (do_push)
			mem_r[wp_r] <= push_data_in;
	end

	// Head read straight from the array, so a pop or a first push shows
	// the right entry on the next cycle; the caller masks it when empty
	always @* begin
		head_out = mem_r[rp_r];
	end
endmodule // ictb_fifo

// file: core/ictb_map.vh
`ifndef ICTB_MAP_VH
`define ICTB_MAP_VH
// Register byte offsets
`define ICTB_CTRL_OFS      8'h00
`define ICTB_STAT_OFS      8'h04
`define ICTB_FIFO_OFS      8'h08
`define ICTB_TBLO_OFS      8'h0c
`define ICTB_TBHI_OFS      8'h10
`define ICTB_IRQ_STAT_OFS  8'h14
`define ICTB_IRQ_MASK_OFS  8'h18
// Control field positions
`define ICTB_EVSEL_LSB     0
`define ICTB_EVSEL_MSB     3
`define ICTB_CAPSEL_BIT    4
`define ICTB_WIDE_BIT      5
`define ICTB_CTRL_RST      6'h00
// Event-select codes
`define ICTB_MODE_EDGE     4'h0
`define ICTB_MODE_RISE     4'h1
`define ICTB_MODE_FALL     4'h2
`define ICTB_MODE_BOTH     4'h3
`define ICTB_MODE_RISE4    4'h4
`define ICTB_MODE_RISE16   4'h5
// Prescale terminal counts
`define ICTB_PS4_LAST      4'h3
`define ICTB_PS16_LAST     4'hf
// Interrupt bits
`define ICTB_IRQ_CAP_BIT   0
`define ICTB_IRQ_OVF_BIT   1
`define ICTB_IRQ_RST       2'h0
`endif

// file: core/ictb_top.v
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "ictb_map.vh"
//Contract
// [RULE_01] Qualified event records the independent timebase
// [RULE_02] Dedicated synchronous up counter, 16/32 bits
// [RULE_03] Each capture pushes timebase into FIFO
// [RULE_04] Timebase readable, lagging by synchronization delay
// [RULE_05] Software sets capture select before use
// [RULE_06] Wide bit picks width; with select, mode
// [RULE_07] Select 0000 is edge-detect capture
// [RULE_08] Select 0001 captures every rising edge
// [RULE_09] Select 0010 captures every falling edge
// [RULE_10] Select 0011 captures both edges
// [RULE_11] Select 0100 captures every fourth rise
// [RULE_12] Select 0101 captures every sixteenth rise
// [RULE_13] Synchronise input, then detect edges
// [RULE_14] Prescaler clears on disable or select change
module ictb_top #(
	parameter FIFO_LOG2 = 2
) (
	input  wire        ref_clk_in,     // System clock 200 MHz
	input  wire        rst_b_in,       // Sync reset, active low
	input  wire        cap_pin_in,     // External capture pin
	input  wire        cap_trig_in,    // Internal trigger source
	input  wire [7:0]  s_axi_awaddr,   // Write address
	input  wire        s_axi_awvalid,  // Write address valid
	output wire        s_axi_awready,  // Write address ready
	input  wire [31:0] s_axi_wdata,    // Write data
	input  wire [3:0]  s_axi_wstrb,    // Write strobes
	input  wire        s_axi_wvalid,   // Write data valid
	output wire        s_axi_wready,   // Write data ready
	output wire [1:0]  s_axi_bresp,    // Write response
	output wire        s_axi_bvalid,   // Write response valid
	input  wire        s_axi_bready,   // Write response ready
	input  wire [7:0]  s_axi_araddr,   // Read address
	input  wire        s_axi_arvalid,  // Read address valid
	output wire        s_axi_arready,  // Read address ready
	output wire [31:0] s_axi_rdata,    // Read data
	output wire [1:0]  s_axi_rresp,    // Read response
	output wire        s_axi_rvalid,   // Read data valid
	input  wire        s_axi_rready,   // Read data ready
	output wire        irq_out         // Level interrupt
);
	// Control register fields
	reg  [5:0]  ctrl_r;
	wire [3:0]  capture_event_select =
		ctrl_r[`ICTB_EVSEL_MSB:`ICTB_EVSEL_LSB];
	wire        capture_function_select = ctrl_r[`ICTB_CAPSEL_BIT];
	wire        wide_timer_select = ctrl_r[`ICTB_WIDE_BIT];
	reg         src_sel_r;        // 0 pin, 1 internal trigger

	// Input synchroniser and edge detect
	reg         sync1_r;
	reg         sync2_r;
	reg         prev_r;
	wire        raw_src = src_sel_r ? cap_trig_in : cap_pin_in;
	wire        rise = sync2_r & ~prev_r;
	wire        fall = ~sync2_r & prev_r;

	// Timebase, prescaler, capture path
	reg  [31:0] tb_r;
	reg  [31:0] tb_view_r;
	reg  [3:0]  ps_r;
	reg  [3:0]  ps_nxt;
	reg  [3:0]  evsel_prev_r;
	reg         cap_evt;
	wire        fifo_empty;
	wire        fifo_full;
	wire [31:0] fifo_head;
	wire [FIFO_LOG2:0] fifo_cnt;
	reg         fifo_pop_r;
	reg  [1:0]  irq_stat_r;
	reg  [1:0]  irq_mask_r;
	wire [1:0]  irq_set;      // Per-bit event pulses
	genvar      gi;
	localparam [1:0] IRQ_RST = `ICTB_IRQ_RST;

	// Bus slave state
	reg         aw_hold_r;
	reg  [7:0]  aw_addr_r;
	reg         w_hold_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;
	reg         bvalid_r;
	reg  [1:0]  bresp_r;
	reg         rvalid_r;
	reg  [31:0] rdata_r;
	reg  [1:0]  rresp_r;
	wire        wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
	wire        rd_go = s_axi_arvalid & ~rvalid_r;
	wire        pop_req = rd_go && (s_axi_araddr == `ICTB_FIFO_OFS);
	wire [1:0]  stat_clr = (wr_go && aw_addr_r == `ICTB_IRQ_STAT_OFS &&
		w_strb_r[0]) ? w_data_r[1:0] : 2'h0;

	// Two-flop synchroniser; only the second stage feeds the edge logic
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= raw_src;     // see [RULE_13]
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Free-running up counter while capture is on; upper half forced to zero in 16-bit
	always @(posedge ref_clk_in) begin
		if (!rst_b_in || !capture_function_select)
			tb_r <= 32'h0;
		else if (wide_timer_select)
			tb_r <= tb_r + 32'h1;               // see [RULE_02]
		else
			tb_r <= {16'h0, tb_r[15:0] + 16'h1}; // see [RULE_02]
	end

	// Read view lags the live count by one sync stage
	always @(posedge ref_clk_in) begin
		if (!rst_b_in)
			tb_view_r <= 32'h0;
		else
			tb_view_r <= tb_r; // see [RULE_04]
	end

	// Event qualification per mode; unlisted codes never capture
	always @* begin
		cap_evt = 1'b0;
		ps_nxt  = ps_r;
		case (capture_event_select) // see [RULE_06]
		`ICTB_MODE_EDGE:  cap_evt = rise | fall;  // see [RULE_07]
		`ICTB_MODE_RISE:  cap_evt = rise;         // see [RULE_08]
		`ICTB_MODE_FALL:  cap_evt = fall;         // see [RULE_09]
		`ICTB_MODE_BOTH:  cap_evt = rise | fall;  // see [RULE_10]
		`ICTB_MODE_RISE4: begin
			if (rise) begin
				cap_evt = (ps_r == `ICTB_PS4_LAST); // see [RULE_11]
				ps_nxt  = cap_evt ? 4'h0 : ps_r + 4'h1;
			end
		end
		`ICTB_MODE_RISE16: begin
			if (rise) begin
				cap_evt = (ps_r == `ICTB_PS16_LAST); // see [RULE_12]
				ps_nxt  = ps_r + 4'h1;
			end
		end
		default: cap_evt = 1'b0;
		endcase
		if (!capture_function_select)
			cap_evt = 1'b0; // see [RULE_05]
	end

	// Prescaler restarts on disable or mode change; a part count left from
	// an earlier select would make the first period short
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			ps_r         <= 4'h0;
			evsel_prev_r <= 4'h0;
		end else begin
			evsel_prev_r <= capture_event_select;
			if (!capture_function_select ||
				evsel_prev_r != capture_event_select)
				ps_r <= 4'h0; // see [RULE_14]
			else
				ps_r <= ps_nxt;
		end
	end

	// Sampled timebase goes straight into the FIFO on the event cycle
	ictb_fifo #(
		.WIDTH      (32),
		.DEPTH_LOG2 (FIFO_LOG2)
	) u_fifo (
		.ref_clk_in   (ref_clk_in),
		.rst_b_in     (rst_b_in),
		.clr_in       (~capture_function_select),
		.push_in      (cap_evt),   // see [RULE_01] see [RULE_03]
		.push_data_in (tb_r),
		.pop_in       (fifo_pop_r),
		.head_out     (fifo_head),
		.empty_out    (fifo_empty),
		.full_out     (fifo_full),
		.count_out    (fifo_cnt)
	);

	// Event sources of the sticky bits: capture done, capture into a full
	// FIFO; a pop in the same cycle frees a slot, so that push is no loss
	assign irq_set[`ICTB_IRQ_CAP_BIT] = cap_evt;
	assign irq_set[`ICTB_IRQ_OVF_BIT] = cap_evt & fifo_full & ~fifo_pop_r;

	// One sticky bit per event; set wins over a write-one clear
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq_bit
			always @(posedge ref_clk_in) begin
				if (!rst_b_in)
					irq_stat_r[gi] <= IRQ_RST[gi];
				else
					irq_stat_r[gi] <= irq_set[gi] |
						(irq_stat_r[gi] & ~stat_clr[gi]);
			end
		end
	endgenerate

	// Level output, high while any unmasked event bit is set
	assign irq_out = |(irq_stat_r & irq_mask_r);

	// Write channel capture; address and data may come in either order
	assign s_axi_awready = ~aw_hold_r;
	assign s_axi_wready  = ~w_hold_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			aw_hold_r  <= 1'b0;
			aw_addr_r  <= 8'h00;
			w_hold_r   <= 1'b0;
			w_data_r   <= 32'h0;
			w_strb_r   <= 4'h0;
			bvalid_r   <= 1'b0;
			bresp_r    <= 2'h0;
			ctrl_r     <= `ICTB_CTRL_RST;
			src_sel_r  <= 1'b0;
			irq_mask_r <= `ICTB_IRQ_RST;
		end else begin
			if (s_axi_awvalid && !aw_hold_r) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_r) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= 2'h0;
				if (aw_addr_r == `ICTB_CTRL_OFS) begin
					if (w_strb_r[0])
						ctrl_r <= w_data_r[5:0];
					if (w_strb_r[1])
						src_sel_r <= w_data_r[8];
				end else if (aw_addr_r == `ICTB_IRQ_MASK_OFS) begin
					if (w_strb_r[0])
						irq_mask_r <= w_data_r[1:0];
				end else if (aw_addr_r == `ICTB_IRQ_STAT_OFS) begin
					bresp_r <= 2'h0;
				end else if (aw_addr_r == `ICTB_STAT_OFS ||
					aw_addr_r == `ICTB_FIFO_OFS ||
					aw_addr_r == `ICTB_TBLO_OFS ||
					aw_addr_r == `ICTB_TBHI_OFS) begin
					bresp_r <= 2'h0;
				end else
					bresp_r <= 2'h2;
			end
		end
	end

	// Read channel; a FIFO read pops the head one cycle later. No second
	// read is taken before the pop lands: arready stays low while rvalid
	// is up, so the next read already sees the new head
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rvalid_r   <= 1'b0;
			rdata_r    <= 32'h0;
			rresp_r    <= 2'h0;
			fifo_pop_r <= 1'b0;
		end else begin
			fifo_pop_r <= pop_req & ~fifo_empty;
			if (rvalid_r && s_axi_rready)
				rvalid_r <= 1'b0;
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rresp_r  <= 2'h0;
				if (s_axi_araddr == `ICTB_CTRL_OFS)
					rdata_r <= {23'h0, src_sel_r, 2'h0, ctrl_r};
				else if (s_axi_araddr == `ICTB_STAT_OFS)
					rdata_r <= {24'h0, {(5-FIFO_LOG2){1'b0}}, fifo_cnt,
						fifo_full, ~fifo_empty};
				else if (s_axi_araddr == `ICTB_FIFO_OFS)
					rdata_r <= fifo_empty ? 32'h0 : fifo_head;
				else if (s_axi_araddr == `ICTB_TBLO_OFS)
					rdata_r <= {16'h0, tb_view_r[15:0]}; // see [RULE_04]
				else if (s_axi_araddr == `ICTB_TBHI_OFS)
					rdata_r <= {16'h0, tb_view_r[31:16]};
				else if (s_axi_araddr == `ICTB_IRQ_STAT_OFS)
					rdata_r <= {30'h0, irq_stat_r};
				else if (s_axi_araddr == `ICTB_IRQ_MASK_OFS)
					rdata_r <= {30'h0, irq_mask_r};
				else begin
					rdata_r <= 32'h0;
					rresp_r <= 2'h2;
				end
			end
		end
	end
endmodule // ictb_top

// file: test/ictb_evt_src.sv
module ictb_evt_src (
	input  wire  ref_clk_in, // Clock
	input  wire  sel_in,     // 1 pulses the trigger
	output logic pin_out,    // Pin line
	output logic trig_out    // Trigger line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lvl = 1'h0;
	logic junk = 1'h0;
	// The line not chosen chatters so a wrong source shows up
	assign pin_out = sel_in ? junk : lvl;
	assign trig_out = sel_in ? lvl : junk;
	// n clean pulses of random width
	task automatic pulse(input int n);
		int i;
		int j;
		int g;
		for (i = 0; i < 2 * n; i++) begin
			g = 3 + $urandom % 5; // Outlasts the sync
			for (j = 0; j < g; j++) begin
				@(posedge ref_clk_in);
				junk <= ~junk;
				if (j == 0)
					lvl <= ~lvl;
			end
		end
	endtask
endmodule // ictb_evt_src

// file: test/ictb_props.sv
module ictb_props #(
	parameter FIFO_LOG2 = 2
) (
	input wire       ref_clk_in,    // Clock
	input wire       rst_b_in,      // Reset
	input wire       cap_pin_in,    // Pin
	input wire       cap_trig_in,   // Trigger
	input wire       s_axi_awvalid, // AW valid
	input wire       s_axi_awready, // AW ready
	input wire       s_axi_wvalid,  // W valid
	input wire       s_axi_wready,  // W ready
	input wire       s_axi_bvalid,  // B valid
	input wire       s_axi_bready,  // B ready
	input wire       s_axi_arvalid, // AR valid
	input wire       s_axi_arready, // AR ready
	input wire [1:0] s_axi_rresp,   // R resp
	input wire       s_axi_rvalid,  // R valid
	input wire       s_axi_rready,  // R ready
	input wire       irq_out        // Interrupt
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic       pin_d_r;
	logic       trig_d_r;
	logic [3:0] quiet_r;
	// Cycles since an event line moved; a capture needs a recent one
	always @(posedge ref_clk_in) begin
		pin_d_r <= cap_pin_in;
		trig_d_r <= cap_trig_in;
		if (!rst_b_in || cap_pin_in != pin_d_r || cap_trig_in != trig_d_r)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	rst_idle_a: assert property (disable iff (1'h0)
		!rst_b_in |=> !s_axi_bvalid && !s_axi_rvalid && !irq_out)
		else $error("Outputs busy after reset");
	aw_refuse_a: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("Second write address taken");
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("No write response");
	b_release_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("Write response repeated");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("No read answer");
	ar_refuse_a: assert property (
		s_axi_arready == !s_axi_rvalid) else $error("Read refusal wrong");
	r_release_a: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("Read answer repeated");
	irq_cause_a: assert property (
		$rose(irq_out) |-> quiet_r < 4'hc || s_axi_bvalid
		|| $past(s_axi_bvalid)) else $error("Interrupt without cause");
	irq_fall_a: assert property (
		$fell(irq_out) |-> s_axi_bvalid || $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2)) else $error("Interrupt fell alone");
	cover property ($rose(irq_out));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property ($fell(irq_out));
endmodule // ictb_props

bind ictb_top ictb_props #(.FIFO_LOG2(FIFO_LOG2)) u_props (.*);

// file: test/input_capture_timebase_tb.sv
module input_capture_timebase_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk_in = 1'h0;
	logic        rst_b_in = 1'h0;
	logic        sel = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h0;
	logic [7:0]  s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid, irq_out;
	wire         cap_pin_in, cap_trig_in;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	int          n_errors = 0;
	int          n_tests = 0;
	int          m, k;
	logic [31:0] q, p;
	logic [1:0]  r;

	ictb_top dut (.*);
	ictb_evt_src src (.ref_clk_in, .sel_in(sel), .pin_out(cap_pin_in),
		.trig_out(cap_trig_in));

	always #2.5 ref_clk_in = ~ref_clk_in;

	task end_sim;
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task ck(input [31:0] g, input [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("Error %0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask

	// One bus transfer; ready is looked at mid-cycle, acted on at the edge
	task xf(input bit w, input [7:0] a, input [31:0] d);
		bit x, y, z, v, dn;
		int i;
		dn = 1'h0;
		@(posedge ref_clk_in);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		for (i = 0; i < 40 && !dn; i++) begin
			@(negedge ref_clk_in);
			x = s_axi_awvalid & s_axi_awready;
			y = s_axi_wvalid & s_axi_wready;
			z = s_axi_arvalid & s_axi_arready;
			v = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge ref_clk_in);
			if (x) s_axi_awvalid <= 1'h0;
			if (y) s_axi_wvalid <= 1'h0;
			if (z) s_axi_arvalid <= 1'h0;
			if (v) begin
				dn = 1'h1;
				s_axi_bready <= 1'h0;
				s_axi_rready <= 1'h0;
			end
		end
		if (!dn) begin
			n_errors++;
			end_sim;
		end
		repeat (2) @(posedge ref_clk_in);
	endtask

	// Captures owed to n whole pulses under each event code
	function automatic int raw(input [3:0] md, input int n);
		case (md)
			4'h0, 4'h3: raw = 2 * n;
			4'h1, 4'h2: raw = n;
			4'h4: raw = n / 4;
			4'h5: raw = n / 16;
			default: raw = 0;
		endcase
	endfunction

	// Clean start, pulses, then flags, interrupt and FIFO contents
	task run(input [3:0] md, input bit t, input bit s, input int n);
		logic [1:0] mk;
		int e, j;
		mk = $urandom % 4;
		sel <= s;
		// Pick the source with capture off, so the switch is no edge
		xf(1'h1, 8'h00, {23'h0, s, 8'h0});
		xf(1'h1, 8'h14, 32'h3);
		xf(1'h1, 8'h18, mk);
		xf(1'h1, 8'h00, {s, 2'h0, t, 1'h1, md});
		src.pulse(n);
		repeat (8) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		e = raw(md, n);
		ck(irq_out, |({e > 4, e > 0} & mk));
		xf(1'h0, 8'h04, 32'h0);
		ck(q[4:2], e > 4 ? 4 : e);
		xf(1'h0, 8'h14, 32'h0);
		ck(q[1:0], {e > 4, e > 0});
		p = 32'h0;
		for (j = 0; j < e && j < 4; j++) begin
			xf(1'h0, 8'h08, 32'h0);
			ck(q > p, 1'h1);
			ck(t ? 16'h0 : q[31:16], 16'h0);
			p = q;
		end
	endtask

	initial begin
		k = $urandom(82820);
		repeat (16) @(posedge ref_clk_in);
		rst_b_in <= 1'h1;
		xf(1'h0, 8'h00, 32'h0);
		ck(q, 32'h0);
		xf(1'h0, 8'h18, 32'h0);
		ck(q, 32'h0);
		xf(1'h1, 8'h40, 32'h1);
		ck(r, 2'h2);
		xf(1'h0, 8'h40, 32'h0);
		ck(r, 2'h2);
		// Timebase counts only while capture is selected
		xf(1'h1, 8'h00, 32'h10);
		xf(1'h0, 8'h0c, 32'h0);
		p = q;
		xf(1'h0, 8'h0c, 32'h0);
		ck(q > p, 1'h1);
		xf(1'h0, 8'h10, 32'h0);
		ck(q, 32'h0);
		xf(1'h1, 8'h00, 32'h0);
		xf(1'h0, 8'h0c, 32'h0);
		ck(q, 32'h0);
		for (m = 0; m < 8; m++)
			run(m, $urandom % 2, $urandom % 2, m < 4 ?
				1 + $urandom % (m % 3 ? 5 : 3) : m == 4 ?
				4 + $urandom % 13 : m == 5 ? 16 + $urandom % 16 : 3);
		run(4'h1, 1'h0, 1'h0, 5);
		// A part count must not survive a select change
		xf(1'h1, 8'h00, 32'h14);
		src.pulse(3);
		xf(1'h1, 8'h00, 32'h15);
		xf(1'h1, 8'h00, 32'h14);
		src.pulse(3);
		repeat (8) @(posedge ref_clk_in);
		xf(1'h0, 8'h04, 32'h0);
		ck(q[4:2], 3'h0);
		end_sim;
	end
endmodule // input_capture_timebase_tb
